// ==== rtl/touch_control_byte_decoder.sv ====
`timescale 1ns/100ps
// Operation
// - bit 7 picks conversion command or register access layout
// - bits 6..3 of a conversion command are function_select
// - resolution_select bit 2: one gives 12-bit results, zero 10-bit
// - soft_reset_bit returns all registers except test_result to defaults, then self-clears
// - halt_conversion_bit aborts the running function, then self-clears
// - access byte: pointer bits 6..3, bias bit 1, read select bit 0; bit 2 zero
// - code 0000 scans X, Y, Z1, Z2 until pen lifts or halt
// - code 0001 scans X and Y until pen lifts or halt
// - codes 0010, 0011, 0100 convert X, Y, or Z1 and Z2 once
// - code 0101 converts auxiliary input once
// - code 0110 makes a temperature measurement into temp one
// - code 0111 makes a differential temperature into temp two
// - code 1000 converts auxiliary input continuously until stopped
// - code 1001 tests X drivers, result on pen pin and status
// - code 1010 tests Y drivers, result on pen pin and status
// - code 1011 reserved; halt clears whatever it left behind
// - code 1100 tests X to Y short through Y, reports on pin and status
// - codes 1101..1111 select driver status for three driver pairs
module touch_control_byte_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control byte from the serial slave, after acknowledge
    input wire logic [7:0] ctl_byte,
    input wire logic ctl_valid,
    // converter side
    input wire logic pen_down,
    input wire logic conv_done,
    input wire logic test_pass,
    output logic conv_start,
    output logic [6:0] conv_chan,
    output logic [3:0] conv_width,
    output logic [3:0] active_func,
    output logic busy,
    output logic [1:0] drv_status_sel,
    // register access side
    output logic [3:0] register_pointer,
    output logic pointer_read_select,
    output logic bias_keep_on_bit,
    output logic ptr_load,
    output logic rsvd_err,
    output logic regs_default,
    // test result
    output logic test_result,
    output logic pen_data_avail_pin
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_CONV = 3'b011,
        ST_WAIT = 3'b010,
        ST_TEST = 3'b110,
        ST_HOLD = 3'b111
    } state_t;

    state_t state_reg;
    logic [3:0] func_reg;
    logic res_reg;
    logic [6:0] pend_reg;
    logic [6:0] rom_chans;
    logic rom_repeat;
    logic is_conv;
    logic is_access;
    logic halt_req;
    logic srst_req;
    logic [3:0] func_next;

    function automatic logic [6:0] low_bit(input logic [6:0] v);
        return v & (~v + 7'h01);
    endfunction

    assign is_conv = ctl_valid && ctl_byte[tcb_pkg::ID_BIT];
    assign is_access = ctl_valid && !ctl_byte[tcb_pkg::ID_BIT];
    assign halt_req = is_conv && ctl_byte[tcb_pkg::HALT_BIT];
    assign srst_req = is_conv && ctl_byte[tcb_pkg::SRST_BIT];

    // next function code
    // also the rom address, so rom output lines up with func_reg
    always_comb begin
        if (srst_req) begin
            func_next = 4'h0;
        end else if (is_conv && !halt_req) begin
            func_next = ctl_byte[tcb_pkg::FIELD_HI:tcb_pkg::FIELD_LO];
        end else begin
            func_next = func_reg;
        end
    end

    chan_seq_rom u_rom (
        .clk(clk),
        .arst_n(arst_n),
        .code(func_next),
        .chans(rom_chans),
        .repeat_on(rom_repeat)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            func_reg <= 4'h0;
            res_reg <= tcb_pkg::RES_RST;
        end else if (srst_req) begin
            func_reg <= 4'h0;
            res_reg <= tcb_pkg::RES_RST;
        end else if (is_conv && !halt_req) begin
            func_reg <= ctl_byte[tcb_pkg::FIELD_HI:tcb_pkg::FIELD_LO];
            res_reg <= ctl_byte[tcb_pkg::RES_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_width <= 4'hC;
        end else if (res_reg) begin
            conv_width <= 4'(tcb_pkg::RES_HI_BITS);
        end else begin
            conv_width <= 4'(tcb_pkg::RES_LO_BITS);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            register_pointer <= tcb_pkg::PTR_RST;
            pointer_read_select <= 1'b0;
            bias_keep_on_bit <= tcb_pkg::BIAS_RST;
            ptr_load <= 1'b0;
            rsvd_err <= 1'b0;
        end else if (srst_req) begin
            register_pointer <= tcb_pkg::PTR_RST;
            pointer_read_select <= 1'b0;
            bias_keep_on_bit <= tcb_pkg::BIAS_RST;
            ptr_load <= 1'b0;
            rsvd_err <= 1'b0;
        end else begin
            ptr_load <= is_access;
            if (is_access) begin
                register_pointer <= ctl_byte[tcb_pkg::FIELD_HI:tcb_pkg::FIELD_LO];
                pointer_read_select <= ctl_byte[tcb_pkg::RDSEL_BIT];
                bias_keep_on_bit <= ctl_byte[tcb_pkg::BIAS_BIT];
                // host owes a zero here; flag a violation
                rsvd_err <= ctl_byte[tcb_pkg::RSVD_BIT];
            end
        end
    end

    // default pulse to the register file
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regs_default <= 1'b0;
        end else begin
            regs_default <= srst_req;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            pend_reg <= 7'h00;
            conv_start <= 1'b0;
            conv_chan <= 7'h00;
        end else if (halt_req || srst_req) begin
            state_reg <= ST_IDLE;
            pend_reg <= 7'h00;
            conv_start <= 1'b0;
            conv_chan <= 7'h00;
        end else begin
            conv_start <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (is_conv) begin
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // rom addressed by func_next, so rom_chans already fits func_reg
                    pend_reg <= rom_chans;
                    if (rom_chans != 7'h00) begin
                        state_reg <= ST_CONV;
                    end else if (func_reg inside {4'h9, 4'hA, 4'hC}) begin
                        // no channel, but the converter still needs a start
                        conv_chan <= 7'h00;
                        conv_start <= 1'b1;
                        state_reg <= ST_TEST;
                    end else begin
                        // reserved and driver status just park
                        state_reg <= ST_HOLD;
                    end
                end
                ST_CONV: begin
                    conv_chan <= low_bit(pend_reg);
                    conv_start <= 1'b1;
                    pend_reg <= pend_reg & ~low_bit(pend_reg);
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done) begin
                        if (pend_reg != 7'h00) begin
                            state_reg <= ST_CONV;
                        end else if (rom_repeat && (pen_down || func_reg == 4'h8)) begin
                            pend_reg <= rom_chans;
                            state_reg <= ST_CONV;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_TEST: begin
                    if (conv_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    state_reg <= ST_HOLD;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            active_func <= 4'h0;
            drv_status_sel <= 2'h0;
        end else begin
            busy <= (state_reg != ST_IDLE) && !halt_req && !srst_req;
            active_func <= func_reg;
            // driver pair select, 1..3 for the three pairs
            drv_status_sel <= (func_reg >= 4'hD) ? 2'(func_reg - 4'hC) : 2'h0;
        end
    end

    // test outcome on pin and status
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_result <= 1'b0;
            pen_data_avail_pin <= 1'b1;
        end else if (halt_req || srst_req) begin
            pen_data_avail_pin <= 1'b1;
        end else if (state_reg == ST_LOAD && func_reg inside {4'h9, 4'hA, 4'hC}) begin
            // pin low while the test runs
            pen_data_avail_pin <= 1'b0;
        end else if (state_reg == ST_TEST && conv_done) begin
            test_result <= test_pass;
            // failure keeps the pin low until halt, soft reset or a later passing test
            pen_data_avail_pin <= test_pass;
        end
    end

    busy_halt_a: assert property (@(posedge clk) disable iff (!arst_n)
        halt_req |=> !busy)
        else $error("busy after halt");
    srst_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
        srst_req |=> regs_default ##1 (!regs_default || $past(srst_req)))
        else $error("soft reset pulse wrong");
    ptr_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        is_access && !srst_req |=> ptr_load && register_pointer == $past(ctl_byte[6:3]))
        else $error("pointer not loaded");
    width_a: assert property (@(posedge clk) disable iff (!arst_n)
        is_conv && !halt_req && !srst_req && ctl_byte[2] |=> ##1 conv_width == 4'hC)
        else $error("width not 12");

    // only a stop, soft reset or a later passing test ends a failed test
    fail_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_TEST && conv_done && !test_pass && !halt_req && !srst_req
        |=> !pen_data_avail_pin [*2] or (##[0:1] $past(halt_req || srst_req)))
        else $error("fail not held");

    // scan, single and continuous aux codes taken in idle, then two quiet cycles
    sequence scan_cmd_s;
        is_conv && !halt_req && !srst_req && state_reg == ST_IDLE
            && ctl_byte[tcb_pkg::FIELD_HI:tcb_pkg::FIELD_LO] < 4'h9;
    endsequence
    sequence no_byte_s;
        !ctl_valid [*2];
    endsequence
    first_start_a: assert property (@(posedge clk) disable iff (!arst_n)
        scan_cmd_s ##1 no_byte_s |=> conv_start && $onehot(conv_chan))
        else $error("first conversion not started");

    // panel tests drop the pin as they are launched
    sequence test_load_s;
        state_reg == ST_LOAD && func_reg inside {4'h9, 4'hA, 4'hC}
            && !halt_req && !srst_req;
    endsequence
    test_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
        test_load_s |=> !pen_data_avail_pin && conv_start)
        else $error("panel test not launched");

    halt_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
        halt_req |=> pen_data_avail_pin && !conv_start && state_reg == ST_IDLE)
        else $error("halt left state behind");
    drv_pair_a: assert property (@(posedge clk) disable iff (!arst_n)
        active_func == 4'hF |-> drv_status_sel == 2'h3)
        else $error("driver pair select wrong");
endmodule

// ==== rtl/tcb_pkg.sv ====
package tcb_pkg;
    // control byte layout
    localparam int ID_BIT = 7;
    localparam int FIELD_HI = 6;
    localparam int FIELD_LO = 3;
    localparam int RES_BIT = 2;
    localparam int SRST_BIT = 1;
    localparam int HALT_BIT = 0;
    localparam int BIAS_BIT = 1;
    localparam int RDSEL_BIT = 0;
    localparam int RSVD_BIT = 2;
    // reset values
    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic RES_RST = 1'b1;
    localparam logic BIAS_RST = 1'b0;
    // result widths selected by resolution_select
    localparam int RES_HI_BITS = 12;
    localparam int RES_LO_BITS = 10;
    // function codes
    typedef enum logic [3:0] {
        FN_SCAN_XYZ = 4'h0,
        FN_SCAN_XY = 4'h1,
        FN_X_ONLY = 4'h2,
        FN_Y_ONLY = 4'h3,
        FN_Z_ONLY = 4'h4,
        FN_AUX_ONE = 4'h5,
        FN_TEMP1 = 4'h6,
        FN_TEMP2 = 4'h7,
        FN_AUX_CONT = 4'h8,
        FN_XCONN = 4'h9,
        FN_YCONN = 4'hA,
        FN_RSVD = 4'hB,
        FN_SHORT = 4'hC,
        FN_DRV_XX = 4'hD,
        FN_DRV_YY = 4'hE,
        FN_DRV_YX = 4'hF
    } func_t;
    // conversion channel one-hot index
    localparam int CH_X = 0;
    localparam int CH_Y = 1;
    localparam int CH_Z1 = 2;
    localparam int CH_Z2 = 3;
    localparam int CH_AUX = 4;
    localparam int CH_T1 = 5;
    localparam int CH_T2 = 6;
    localparam int CH_N = 7;
endpackage

// ==== rtl/chan_seq_rom.sv ====
`timescale 1ns/100ps
// function code to channel set table, registered read
module chan_seq_rom (
    // clock
    input wire logic clk,
    input wire logic arst_n,
    // lookup
    input wire logic [3:0] code,
    output logic [6:0] chans,
    output logic repeat_on
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chans <= 7'h00;
            repeat_on <= 1'b0;
        end else begin
            unique case (code)
                4'h0: begin
                    chans <= 7'h0F;
                    repeat_on <= 1'b1;
                end
                4'h1: begin
                    chans <= 7'h03;
                    repeat_on <= 1'b1;
                end
                4'h2: begin
                    chans <= 7'h01;
                    repeat_on <= 1'b0;
                end
                4'h3: begin
                    chans <= 7'h02;
                    repeat_on <= 1'b0;
                end
                4'h4: begin
                    chans <= 7'h0C;
                    repeat_on <= 1'b0;
                end
                4'h5: begin
                    chans <= 7'h10;
                    repeat_on <= 1'b0;
                end
                4'h6: begin
                    chans <= 7'h20;
                    repeat_on <= 1'b0;
                end
                4'h7: begin
                    chans <= 7'h40;
                    repeat_on <= 1'b0;
                end
                4'h8: begin
                    chans <= 7'h10;
                    repeat_on <= 1'b1;
                end
                default: begin
                    chans <= 7'h00;
                    repeat_on <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ==== dv/conv_model.sv ====
`timescale 1ns/100ps
// converter stand-in: answers every start after a settable delay
module conv_model (
    // clock
    input wire logic clk,
    // handshake
    input wire logic conv_start,
    input wire logic [3:0] dly,
    input wire logic pass,
    output logic conv_done,
    output logic test_pass
);
    int cnt = 0;
    initial conv_done = 1'b0;
    initial test_pass = 1'b0;
    // outcome only meaningful with done, so it toggles otherwise
    always @(posedge clk) begin
        conv_done <= 1'b0;
        test_pass <= ~test_pass;
        if (conv_start) begin
            cnt <= int'(dly) + 1;
        end else if (cnt == 1) begin
            conv_done <= 1'b1;
            test_pass <= pass;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] ctl_byte = 8'h00;
    logic ctl_valid = 1'b0;
    logic pen_down = 1'b0;
    logic [3:0] dly = 4'h0;
    logic pass = 1'b1;
    logic conv_done, test_pass, conv_start, busy, ptr_load, rsvd_err, regs_default;
    logic pointer_read_select, bias_keep_on_bit, test_result, pen_data_avail_pin;
    logic [6:0] conv_chan;
    logic [3:0] conv_width, active_func, register_pointer;
    logic [1:0] drv_status_sel;
    logic [7:0] b;
    int err_total = 0;
    int n_compared = 0;
    int seed = 12;
    int c;

    always #10 clk = ~clk;

    touch_control_byte_decoder i_dut (.clk(clk), .arst_n(arst_n), .ctl_byte(ctl_byte),
        .ctl_valid(ctl_valid), .pen_down(pen_down), .conv_done(conv_done),
        .test_pass(test_pass), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_width(conv_width), .active_func(active_func), .busy(busy),
        .drv_status_sel(drv_status_sel), .register_pointer(register_pointer),
        .pointer_read_select(pointer_read_select), .bias_keep_on_bit(bias_keep_on_bit),
        .ptr_load(ptr_load), .rsvd_err(rsvd_err), .regs_default(regs_default),
        .test_result(test_result), .pen_data_avail_pin(pen_data_avail_pin));

    conv_model i_conv (.clk(clk), .conv_start(conv_start), .dly(dly), .pass(pass),
        .conv_done(conv_done), .test_pass(test_pass));

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] v);
        @(posedge clk);
        #1 ctl_byte = v;
        ctl_valid = 1'b1;
        @(posedge clk);
        #1 ctl_valid = 1'b0;
    endtask

    // bounded wait: 0 start, 1 pointer load, 2 idle, 3 defaults, 4 done
    task automatic waitc(input int k);
        int i;
        logic hit;
        hit = 1'b0;
        for (i = 0; i < 80 && !hit; i++) begin
            @(posedge clk);
            #1;
            case (k)
                0: hit = (conv_start === 1'b1);
                1: hit = (ptr_load === 1'b1);
                2: hit = (busy === 1'b0);
                3: hit = (regs_default === 1'b1);
                default: hit = (conv_done === 1'b1);
            endcase
        end
        if (!hit) check(8'(k), 8'hFF);
    endtask

    function automatic logic [6:0] first_chan(input logic [3:0] f);
        case (f)
            4'h3: return 7'h02;
            4'h4: return 7'h04;
            4'h5, 4'h8: return 7'h10;
            4'h6: return 7'h20;
            4'h7: return 7'h40;
            default: return 7'h01;
        endcase
    endfunction

    initial begin
        #1_000_000;
        err_total++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        check(8'(conv_width), 8'h0C);
        check(8'(pen_data_avail_pin), 8'h01);
        repeat (8) begin
            // host keeps reserved bit 2 clear
            b = 8'($random(seed)) & 8'h7B;
            send(b);
            check(8'(ptr_load), 8'h01);
            check(8'(register_pointer), 8'(b[6:3]));
            check({6'h00, bias_keep_on_bit, pointer_read_select}, 8'(b[1:0]));
            check(8'(rsvd_err), 8'(b[2]));
        end
        // corner: reserved bit set on purpose must raise the flag
        send(8'h7C);
        check({3'h0, rsvd_err, register_pointer}, 8'h1F);
        for (c = 2; c < 8; c++) begin
            b = {1'b1, 4'(c), 1'($random(seed)), 2'b00};
            dly = 4'($random(seed));
            send(b);
            waitc(0);
            check(8'(conv_chan), 8'(first_chan(4'(c))));
            check(8'(conv_width), b[2] ? 8'h0C : 8'h0A);
            check(8'(active_func), 8'(c));
            waitc(2);
        end
        dly = 4'h1;
        pen_down = 1'b1;
        send(8'h80);
        repeat (6) waitc(0);
        check(8'(busy), 8'h01);
        pen_down = 1'b0;
        waitc(2);
        pen_down = 1'b1;
        send(8'h88);
        repeat (3) waitc(0);
        send(8'h81);
        waitc(2);
        check(8'(busy), 8'h00);
        pen_down = 1'b0;
        send(8'hC0);
        repeat (3) waitc(0);
        check(8'(conv_chan), 8'h10);
        check(8'(busy), 8'h01);
        send(8'h81);
        waitc(2);
        for (c = 0; c < 6; c++) begin
            pass = c[0];
            b = (c < 2) ? 8'hCC : (c < 4) ? 8'hD4 : 8'hE4;
            send(b);
            waitc(0);
            check(8'(pen_data_avail_pin), 8'h00);
            waitc(4);
            @(posedge clk);
            #1 check(8'(pen_data_avail_pin), 8'(pass));
            check(8'(test_result), 8'(pass));
            repeat (3) @(posedge clk);
            #1 check(8'(pen_data_avail_pin), 8'(pass));
            send(8'h81);
            waitc(2);
            repeat (2) @(posedge clk);
            #1 check(8'(pen_data_avail_pin), 8'h01);
        end
        for (c = 11; c < 16; c++) begin
            if (c != 12) begin
                send({1'b1, 4'(c), 3'b000});
                repeat (4) @(posedge clk);
                #1 check(8'(busy), 8'h01);
                check(8'(drv_status_sel), (c > 12) ? 8'(c - 12) : 8'h00);
                send(8'h81);
                waitc(2);
                check(8'(busy), 8'h00);
            end
        end
        send(8'h5B);
        send(8'h90);
        waitc(0);
        waitc(2);
        send(8'h82);
        check(8'(regs_default), 8'h01);
        @(posedge clk);
        #1 check(8'(register_pointer), 8'h00);
        check({6'h00, bias_keep_on_bit, pointer_read_select}, 8'h00);
        check(8'(conv_width), 8'h0C);
        finish_test();
    end
endmodule
